//--- dv/sensor_capability_config_regs_monitor.sv
// checker for the capability and configuration register block
// sees only the block's ports; attached by the bind below
`default_nettype none
module sensor_capability_config_regs_monitor
  import sensor_regs_pkg::*;
#(
  parameter int unsigned TEMP_W         = 13,
  parameter logic [1:0]  RESOLUTION_SEL = 2'h1,
  parameter logic        ACCURACY_GRADE = 1'b1
) (
  input wire logic                                i_sys_clk,
  input wire logic                                i_rst,
  input wire logic                                i_clk_en,
  input wire logic [sensor_regs_pkg::PTR_W-1:0]   i_reg_ptr,
  input wire logic                                i_rd_en,
  input wire logic [sensor_regs_pkg::DATA_W-1:0]  o_rd_data,
  input wire logic signed [TEMP_W-1:0]            o_ambient_temperature,
  input wire logic                                o_conv_enable,
  input wire logic                                o_critical_lock,
  input wire logic                                o_window_lock
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // ---------------------------------------------------------------
  // read path: taken edge, then one enabled edge to the output; the checks wait two
  // ---------------------------------------------------------------
  sequence rd_drain;
    i_clk_en ##1 i_clk_en;
  endsequence
  cap_word_a: assert property (i_clk_en && i_rd_en && i_reg_ptr == PTR_CAPABILITY ##1 rd_drain |=>
    o_rd_data == {11'h000, RESOLUTION_SEL, 1'b0, ACCURACY_GRADE, ALARM_PRESENT}) else $error("capability word wrong");
  unmapped_zero_a: assert property (i_clk_en && i_rd_en && i_reg_ptr > PTR_CONFIG ##1 rd_drain |=>
    o_rd_data == WORD_RST) else $error("unmapped pointer read not zero");
  cfg_reserved_a: assert property (i_clk_en && i_rd_en && i_reg_ptr == PTR_CONFIG ##1 rd_drain |=>
    o_rd_data[15:11] == 5'h00 && !o_rd_data[CFG_ICLR_BIT]) else $error("reserved config bits not zero");
  lock_readback_a: assert property ((o_rd_data[7:6] & ~{o_critical_lock, o_window_lock}) == 2'h0)
    else $error("lock bits read set but lock outputs low");
  // four idle cycles cover the two-edge sample latency
  halt_hold_a: assert property (!o_conv_enable [*4] |-> $stable(o_ambient_temperature))
    else $error("ambient changed while halted");
  conv_restart_a: assert property ($fell(i_rst) && i_clk_en |-> !o_conv_enable ##1 o_conv_enable)
    else $error("conversion enable wrong after reset");
  crit_sticky_a: assert property (o_critical_lock |=> o_critical_lock)
    else $error("critical lock dropped");
  win_sticky_a: assert property (o_window_lock |=> o_window_lock)
    else $error("window lock dropped");
endmodule
bind sensor_capability_config_regs sensor_capability_config_regs_monitor #(
  .TEMP_W(TEMP_W), .RESOLUTION_SEL(RESOLUTION_SEL), .ACCURACY_GRADE(ACCURACY_GRADE)
) i_mon (.i_sys_clk, .i_rst, .i_clk_en, .i_reg_ptr, .i_rd_en, .o_rd_data, .o_ambient_temperature,
  .o_conv_enable, .o_critical_lock, .o_window_lock);
`default_nettype wire

//--- dv/sensor_capability_config_regs_tb.sv
// self-checking bench for the capability and configuration registers
// assumes the host model drives the register port; samples come from here
`default_nettype none
module sensor_capability_config_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sensor_regs_pkg::*;
  logic               clk, clk_en, rst, wr_en, rd_en, conv_valid, conv_en, crit_lock, win_lock, event_pin;
  logic [7:0]         reg_ptr;
  logic [15:0]        wr_data, rd_data, word;
  logic signed [12:0] conv_temp, upper, lower, crit, ambient;
  int                 mismatches, total_checks, cycles;
  sensor_host_model i_host (.i_sys_clk(clk), .i_rd_data(rd_data), .o_reg_ptr(reg_ptr), .o_wr_en(wr_en),
    .o_wr_data(wr_data), .o_rd_en(rd_en));
  sensor_capability_config_regs i_dut (.i_sys_clk(clk), .i_rst(rst), .i_clk_en(clk_en), .i_reg_ptr(reg_ptr),
    .i_wr_en(wr_en), .i_wr_data(wr_data), .i_rd_en(rd_en), .o_rd_data(rd_data), .i_conv_valid(conv_valid),
    .i_conv_temp(conv_temp), .i_upper_limit(upper), .i_lower_limit(lower), .i_critical_limit(crit),
    .o_ambient_temperature(ambient), .o_conv_enable(conv_en), .o_critical_lock(crit_lock),
    .o_window_lock(win_lock), .o_event_pin(event_pin));
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic rd_cfg(input logic [15:0] exp, input string what);
    i_host.rd_reg(PTR_CONFIG, word);
    check(what, word, exp);
  endtask
  // sample lands on the pin two edges after it is taken
  task automatic sample(input logic signed [12:0] t);
    @(posedge clk);
    conv_valid <= 1'b1;
    conv_temp  <= t;
    @(posedge clk);
    conv_valid <= 1'b0;
    conv_temp  <= ~t;
    repeat (3) @(posedge clk);
    #1;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      give_verdict();
    end
  end
  initial begin
    {rst, conv_valid, conv_temp, mismatches, total_checks, cycles} = {1'b1, 1'b0, 13'h0000, 96'h0};
    {upper, lower, crit} = {13'h0100, 13'h1F00, 13'h0FF0};
    clk_en = 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    i_host.rd_reg(PTR_CAPABILITY, word);
    check("capability", word, 16'h000B);
    i_host.wr_reg(PTR_CAPABILITY, 16'hFFFF);
    i_host.rd_reg(PTR_CAPABILITY, word);
    check("capability after write", word, 16'h000B);
    i_host.rd_reg(8'h02, word);
    check("unmapped", word, 16'h0000);
    // a write while the enable is low must not land
    clk_en <= 1'b0;
    i_host.wr_reg(PTR_CONFIG, 16'h0200);
    clk_en <= 1'b1;
    rd_cfg(16'h0000, "config reset");
    for (int h = 0; h < 4; h++) begin
      i_host.wr_reg(PTR_CONFIG, 16'hF820 | 16'(h << 9));
      rd_cfg(16'(h << 9), "hysteresis code");
    end
    sample(13'h0040);
    check("ambient", 16'(ambient), 16'h0040);
    i_host.wr_reg(PTR_CONFIG, 16'h0100);
    rd_cfg(16'h0100, "halt select");
    check("conv enable", 16'(conv_en), 16'h0000);
    i_host.wr_reg(PTR_CONFIG, 16'h0300);
    rd_cfg(16'h0300, "hysteresis in halt");
    sample(13'h0055);
    check("ambient held", 16'(ambient), 16'h0040);
    i_host.wr_reg(PTR_CONFIG, 16'h000A);
    sample(13'h0200);
    check("event pin", 16'(event_pin), 16'h0001);
    rd_cfg(16'h001A, "event status");
    i_host.wr_reg(PTR_CONFIG, 16'h010A);
    repeat (4) @(posedge clk);
    check("event pin halted", 16'(event_pin), 16'h0000);
    rd_cfg(16'h010A, "status halted");
    i_host.wr_reg(PTR_CONFIG, 16'h060A);
    sample(13'h0200);
    sample(13'h00F0);
    check("pin inside band", 16'(event_pin), 16'h0001);
    sample(13'h00A0);
    check("pin below band", 16'(event_pin), 16'h0000);
    i_host.wr_reg(PTR_CONFIG, 16'h062B);
    sample(13'h0200);
    check("interrupt pin", 16'(event_pin), 16'h0001);
    i_host.wr_reg(PTR_CONFIG, 16'h062B);
    rd_cfg(16'h060B, "interrupt cleared");
    check("pin after clear", 16'(event_pin), 16'h0000);
    sample(13'h00A0);
    i_host.wr_reg(PTR_CONFIG, 16'h010A);
    i_host.wr_reg(PTR_CONFIG, 16'h018A);
    i_host.wr_reg(PTR_CONFIG, 16'h0600);
    rd_cfg(16'h008A, "locked write");
    check("critical lock", 16'(crit_lock), 16'h0001);
    i_host.wr_reg(PTR_CONFIG, 16'h01CA);
    rd_cfg(16'h00CA, "halt while locked");
    check("window lock", 16'(win_lock), 16'h0001);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_cfg(16'h0000, "config after reset");
    check("pin idle after reset", 16'(event_pin), 16'h0001);
    give_verdict();
  end
endmodule
`default_nettype wire

//--- dv/sensor_host_model.sv
// host model: pointer, write and read strobes of the register port
// assumes a free-running system clock; tasks are called by the bench
`default_nettype none
module sensor_host_model
  import sensor_regs_pkg::*;
(
  input  wire logic                                i_sys_clk,
  input  wire logic [sensor_regs_pkg::DATA_W-1:0]  i_rd_data,
  output var  logic [sensor_regs_pkg::PTR_W-1:0]   o_reg_ptr,
  output var  logic                                o_wr_en,
  output var  logic [sensor_regs_pkg::DATA_W-1:0]  o_wr_data,
  output var  logic                                o_rd_en
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_reg_ptr = 8'hFF;
    o_wr_en   = 1'b0;
    o_wr_data = 16'h0000;
    o_rd_en   = 1'b0;
  end
  task automatic wr_reg(input logic [7:0] ptr, input logic [15:0] data);
    @(posedge i_sys_clk);
    o_reg_ptr <= ptr;
    o_wr_en   <= 1'b1;
    o_wr_data <= data;
    @(posedge i_sys_clk);
    o_wr_en   <= 1'b0;
    o_wr_data <= ~data;  // released data must not look stale
  endtask
  task automatic rd_reg(input logic [7:0] ptr, output logic [15:0] data);
    @(posedge i_sys_clk);
    o_reg_ptr <= ptr;
    o_rd_en   <= 1'b1;
    @(posedge i_sys_clk);
    o_rd_en   <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    #1 data = i_rd_data;
  endtask
endmodule
`default_nettype wire

//--- src/sensor_capability_config_regs.sv
// capability and configuration registers of the temperature sensor,
// with boundary compare, hysteresis, shutdown and event pin control
// assumes the serial front end decodes frames into pointer/read/write
// strobes synchronous to i_sys_clk, and the converter delivers samples
`default_nettype none
module sensor_capability_config_regs
  import sensor_regs_pkg::*;
#(
  parameter int unsigned TEMP_W         = 13,
  parameter logic [1:0]  RESOLUTION_SEL = sensor_regs_pkg::RES_0P25,
  parameter logic        ACCURACY_GRADE = 1'b1
) (
  input  wire logic                                i_sys_clk,
  input  wire logic                                i_rst,
  input  wire logic                                i_clk_en,
  input  wire logic [sensor_regs_pkg::PTR_W-1:0]   i_reg_ptr,
  input  wire logic                                i_wr_en,
  input  wire logic [sensor_regs_pkg::DATA_W-1:0]  i_wr_data,
  input  wire logic                                i_rd_en,
  output var  logic [sensor_regs_pkg::DATA_W-1:0]  o_rd_data,
  input  wire logic                                i_conv_valid,
  input  wire logic signed [TEMP_W-1:0]            i_conv_temp,
  input  wire logic signed [TEMP_W-1:0]            i_upper_limit,
  input  wire logic signed [TEMP_W-1:0]            i_lower_limit,
  input  wire logic signed [TEMP_W-1:0]            i_critical_limit,
  output var  logic signed [TEMP_W-1:0]            o_ambient_temperature,
  output var  logic                                o_conv_enable,
  output var  logic                                o_critical_lock,
  output var  logic                                o_window_lock,
  output var  logic                                o_event_pin
);
  import sensor_regs_pkg::*;

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (TEMP_W < TEMP_W_MIN || TEMP_W > TEMP_W_MAX) begin : g_bad_width
    $error("temperature width out of range");
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  localparam int unsigned EXT_W = TEMP_W + 1;

  function automatic logic [7:0] hyst_lsb(input logic [1:0] sel);
    case (sel)
      2'h0:    hyst_lsb = HYST_0P0_LSB;
      2'h1:    hyst_lsb = HYST_1P5_LSB;
      2'h2:    hyst_lsb = HYST_3P0_LSB;
      default: hyst_lsb = HYST_6P0_LSB;
    endcase
  endfunction

  function automatic logic signed [EXT_W-1:0] sext(input logic signed [TEMP_W-1:0] v);
    sext = {v[TEMP_W-1], v};
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [1:0]               hyst_reg;
  logic                     halt_reg;
  logic                     crit_lock_reg;
  logic                     win_lock_reg;
  logic                     ev_en_reg;
  logic                     ev_sel_reg;
  logic                     ev_pol_reg;
  logic                     ev_mode_reg;
  logic                     ev_stat_reg;
  logic                     int_latch_reg;
  logic                     above_reg;
  logic                     below_reg;
  logic                     crit_reg;
  logic signed [TEMP_W-1:0] ambient_reg;
  logic [DATA_W-1:0]        rd_reg;
  logic                     pin_reg;

  // ---------------------------------------------------------------
  // register write decode
  // ---------------------------------------------------------------
  wire logic wr_cfg   = i_wr_en && (i_reg_ptr == PTR_CONFIG);
  wire logic any_lock = crit_lock_reg | win_lock_reg;
  wire logic wd_halt  = i_wr_data[CFG_HALT_BIT];

  // locked fields keep their value, except that halt can still be cleared; the rest of the word still lands
  wire logic [1:0] hyst_next = (wr_cfg && !any_lock)
                               ? i_wr_data[CFG_HYST_LSB +: 2] : hyst_reg;
  wire logic halt_next       = !wr_cfg ? halt_reg
                               : (wd_halt ? (halt_reg | ~any_lock) : 1'b0);
  wire logic crit_lock_next  = crit_lock_reg | (wr_cfg & i_wr_data[CFG_CLOCK_BIT]);
  wire logic win_lock_next   = win_lock_reg | (wr_cfg & i_wr_data[CFG_WLOCK_BIT]);
  wire logic ev_en_next      = (wr_cfg && !any_lock) ? i_wr_data[CFG_EN_BIT] : ev_en_reg;
  wire logic ev_sel_next     = (wr_cfg && !win_lock_reg) ? i_wr_data[CFG_SEL_BIT] : ev_sel_reg;
  wire logic ev_pol_next     = (wr_cfg && !any_lock) ? i_wr_data[CFG_POL_BIT] : ev_pol_reg;
  wire logic ev_mode_next    = (wr_cfg && !any_lock) ? i_wr_data[CFG_MODE_BIT] : ev_mode_reg;
  // clear is a strobe only; the bit never stores and reads zero
  wire logic int_clear       = wr_cfg & i_wr_data[CFG_ICLR_BIT];

  // ---------------------------------------------------------------
  // boundary compare with hysteresis
  // ---------------------------------------------------------------
  // frozen in shutdown so the held sample keeps its flags
  wire logic take_sample = i_conv_valid & ~halt_reg;
  wire logic signed [EXT_W-1:0] t_ext     = sext(i_conv_temp);
  wire logic signed [EXT_W-1:0] hyst_ext  = $signed({{(EXT_W-8){1'b0}}, hyst_lsb(hyst_reg)});
  wire logic signed [EXT_W-1:0] up_rel    = sext(i_upper_limit) - hyst_ext;
  wire logic signed [EXT_W-1:0] lo_rel    = sext(i_lower_limit) + hyst_ext;

  // set on the crossing, release only once back inside by the hysteresis
  wire logic above_next = (t_ext > sext(i_upper_limit)) ? 1'b1
                          : ((t_ext <= up_rel) ? 1'b0 : above_reg);
  wire logic below_next = (t_ext < sext(i_lower_limit)) ? 1'b1
                          : ((t_ext >= lo_rel) ? 1'b0 : below_reg);
  wire logic crit_next  = t_ext >= sext(i_critical_limit);

  wire logic win_now    = above_reg | below_reg;
  wire logic win_change = take_sample & ((above_next | below_next) != win_now);
  // a window change in the clear cycle is kept: set beats clear
  wire logic int_latch_next = win_change | (int_latch_reg & ~int_clear);

  // ---------------------------------------------------------------
  // event output
  // ---------------------------------------------------------------
  wire logic cmp_cond  = ev_sel_reg ? crit_reg : (win_now | crit_reg);
  wire logic int_cond  = (~ev_sel_reg & int_latch_reg) | crit_reg;
  wire logic ev_active = ev_en_reg & ~halt_reg
                         & (ev_mode_reg ? int_cond : cmp_cond);
  // inactive level is high for active-low polarity (pulled up externally)
  wire logic pin_next  = ev_pol_reg ? ev_active : ~ev_active;

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  wire logic [DATA_W-1:0] cap_word = {{(DATA_W-5){1'b0}}, RESOLUTION_SEL, 1'b0,
                                      ACCURACY_GRADE, ALARM_PRESENT};
  wire logic [DATA_W-1:0] cfg_word = {5'h00, hyst_reg, halt_reg, crit_lock_reg, win_lock_reg,
                                      1'b0, ev_stat_reg, ev_en_reg, ev_sel_reg,
                                      ev_pol_reg, ev_mode_reg};
  wire logic [DATA_W-1:0] rd_word  = (i_reg_ptr == PTR_CAPABILITY) ? cap_word
                                   : (i_reg_ptr == PTR_CONFIG) ? cfg_word : WORD_RST;

  // ---------------------------------------------------------------
  // configuration flops
  // ---------------------------------------------------------------
  // registers stay reachable in shutdown: no gating by halt here
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      hyst_reg      <= HYST_RST;
      halt_reg      <= BIT_RST;
      crit_lock_reg <= BIT_RST;
      win_lock_reg  <= BIT_RST;
      ev_en_reg     <= BIT_RST;
      ev_sel_reg    <= BIT_RST;
      ev_pol_reg    <= BIT_RST;
      ev_mode_reg   <= BIT_RST;
    end else if (i_clk_en) begin
      hyst_reg      <= hyst_next;
      halt_reg      <= halt_next;
      crit_lock_reg <= crit_lock_next;
      win_lock_reg  <= win_lock_next;
      ev_en_reg     <= ev_en_next;
      ev_sel_reg    <= ev_sel_next;
      ev_pol_reg    <= ev_pol_next;
      ev_mode_reg   <= ev_mode_next;
    end
  end

  // ---------------------------------------------------------------
  // sample and compare flops
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      ambient_reg <= '0;
      above_reg   <= BIT_RST;
      below_reg   <= BIT_RST;
      crit_reg    <= BIT_RST;
    end else if (i_clk_en && take_sample) begin
      ambient_reg <= i_conv_temp;
      above_reg   <= above_next;
      below_reg   <= below_next;
      crit_reg    <= crit_next;
    end
  end

  // ---------------------------------------------------------------
  // event and read-back flops
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      int_latch_reg <= BIT_RST;
      ev_stat_reg   <= BIT_RST;
      pin_reg       <= 1'b1;
      rd_reg        <= WORD_RST;
    end else if (i_clk_en) begin
      int_latch_reg <= int_latch_next;
      ev_stat_reg   <= ev_active;
      pin_reg       <= pin_next;
      if (i_rd_en) begin
        rd_reg <= rd_word;
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rd_data             <= WORD_RST;
      o_ambient_temperature <= '0;
      o_conv_enable         <= 1'b0;
      o_critical_lock       <= BIT_RST;
      o_window_lock         <= BIT_RST;
      o_event_pin           <= 1'b1;
    end else if (i_clk_en) begin
      o_rd_data             <= rd_reg;
      o_ambient_temperature <= ambient_reg;
      o_conv_enable         <= ~halt_reg;
      o_critical_lock       <= crit_lock_reg;
      o_window_lock         <= win_lock_reg;
      o_event_pin           <= pin_reg;
    end
  end
endmodule
`default_nettype wire

//--- src/sensor_regs_pkg.sv
// constants for the sensor capability and configuration register logic
// assumes one system clock and a temperature lsb of 0.0625 C
`default_nettype none
package sensor_regs_pkg;
  // ---------------------------------------------------------------
  // register pointer and data widths
  // ---------------------------------------------------------------
  localparam int unsigned    PTR_W          = 8;
  localparam int unsigned    DATA_W         = 16;
  localparam logic [7:0]     PTR_CAPABILITY = 8'h00;
  localparam logic [7:0]     PTR_CONFIG     = 8'h01;
  // ---------------------------------------------------------------
  // capability field positions and values
  // ---------------------------------------------------------------
  localparam int unsigned    CAP_RES_LSB    = 3;
  localparam int unsigned    CAP_ACC_BIT    = 1;
  localparam int unsigned    CAP_ALARM_BIT  = 0;
  localparam logic [1:0]     RES_0P25       = 2'h1;
  localparam logic           ALARM_PRESENT  = 1'b1;
  // ---------------------------------------------------------------
  // configuration field positions
  // ---------------------------------------------------------------
  localparam int unsigned    CFG_HYST_LSB   = 9;
  localparam int unsigned    CFG_HALT_BIT   = 8;
  localparam int unsigned    CFG_CLOCK_BIT  = 7;
  localparam int unsigned    CFG_WLOCK_BIT  = 6;
  localparam int unsigned    CFG_ICLR_BIT   = 5;
  localparam int unsigned    CFG_STAT_BIT   = 4;
  localparam int unsigned    CFG_EN_BIT     = 3;
  localparam int unsigned    CFG_SEL_BIT    = 2;
  localparam int unsigned    CFG_POL_BIT    = 1;
  localparam int unsigned    CFG_MODE_BIT   = 0;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [1:0]     HYST_RST       = 2'h0;
  localparam logic           BIT_RST        = 1'b0;
  localparam logic [15:0]    WORD_RST       = 16'h0000;
  // ---------------------------------------------------------------
  // hysteresis in temperature lsbs (0.0625 C each)
  // ---------------------------------------------------------------
  localparam logic [7:0]     HYST_0P0_LSB   = 8'h00;
  localparam logic [7:0]     HYST_1P5_LSB   = 8'h18;
  localparam logic [7:0]     HYST_3P0_LSB   = 8'h30;
  localparam logic [7:0]     HYST_6P0_LSB   = 8'h60;
  localparam int unsigned    TEMP_W_MIN     = 8;
  localparam int unsigned    TEMP_W_MAX     = 16;
endpackage
`default_nettype wire
